// [slcfg_consts.svh]
`ifndef SLCFG_CONSTS_SVH
`define SLCFG_CONSTS_SVH
// register offsets
`define SLCFG_A_FMT      8'h14
`define SLCFG_A_SYNCOPT  8'h3A
`define SLCFG_A_QUICK    8'h5E
`define SLCFG_A_LINK     8'h5F
`define SLCFG_A_POL      8'h60
`define SLCFG_A_DEVID    8'h64
`define SLCFG_A_BANKID   8'h65
`define SLCFG_A_LANE0ID  8'h66
`define SLCFG_A_LANE1ID  8'h67
`define SLCFG_A_SCRL     8'h6E
`define SLCFG_A_OCTF     8'h6F
`define SLCFG_A_FRAMES   8'h70
`define SLCFG_A_CONVS    8'h71
`define SLCFG_A_CTLBITS  8'h72
`define SLCFG_A_SWIDTH   8'h73
`define SLCFG_A_SPF      8'h74
`define SLCFG_A_DENSITY  8'h75
`define SLCFG_A_CHK0     8'h78
`define SLCFG_A_CHK3     8'h7B
`define SLCFG_A_REMAPA   8'h82
`define SLCFG_A_REMAPB   8'h83
// field positions
`define SLCFG_B_TAILRND  6
`define SLCFG_B_LINKRST  0
`define SLCFG_B_INVERT   1
`define SLCFG_B_SCR      7
// reset values
`define SLCFG_R_QUICK    8'h41
`define SLCFG_R_FRAMES   5'h1F
`define SLCFG_R_CTLBITS  8'h0F
`define SLCFG_R_REMAPA   8'h10
`define SLCFG_R_REMAPB   8'h32
// fixed link parameters, as transmitted (minus one where coded)
`define SLCFG_NP_M1      5'h0F
`define SLCFG_N14_M1     5'h0D
`define SLCFG_SUBCLASS   3'h1
`define SLCFG_JESDV      3'h1
`define SLCFG_K_START    8'h9C
`define SLCFG_CFG_LAST   4'hD
`endif

// [slcfg_pkg.sv]
package slcfg_pkg;
   typedef enum logic [2:0]
   {
      SLCFG_IDLE = 3'b001,
      SLCFG_QCH  = 3'b010,
      SLCFG_CFG  = 3'b100
   } slcfg_ilas_e;

   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } slcfg_bus_s;

   typedef struct packed
   {
      logic       valid;
      logic       k;
      logic [7:0] octet;
   } slcfg_ilas_s;

   typedef struct packed
   {
      logic       ok;
      logic [7:0] m;
      logic [4:0] l;
      logic [7:0] f;
   } slcfg_qc_s;

   typedef logic [7:0] slcfg_chk_t [4];
endpackage

// [slcfg_top.sv]
`timescale 1ns/1ps
`include "slcfg_consts.svh"
// Summary of operation
// - 14-bit samples padded with two tail bits
// - tail bits zero or pseudorandom per select
// - control bits replace tail bits by count
// - device, bank, lane ids held and sent
// - multiframe frame count is field plus one
// - octets per frame derived, read-only
// - scrambling enabled, active after lane sync
// - alignment sequence on, off, or repeating
// - sample width reads as 16
// - control words per frame read zero
// - lane count readable, read-only
// - high density flag reads zero
// - converter count readable
// - one sample per converter per frame
// - per-lane checksum sent and readable
// - checksum is modulo-256 field sum
// - lane checksums at four read offsets
// - configuration octets packed in order
// - serial output polarity inversion bit
// - offset binary or two's complement output
// - sync pin options and lane remap
// - link reset bit holds link idle
// - start character then 14 config octets
// - quick configuration codes select M and L
module slcfg_top
(
   input  wire logic                sys_clk_i,
   input  wire logic                resetn_i,
   input  wire slcfg_pkg::slcfg_bus_s bus_i,
   output logic [7:0]               rd_data_o,
   input  wire logic [15:0]         sample_i,
   input  wire logic [1:0]          ctrl_flags_i,
   input  wire logic                ilas_start_i,
   input  wire logic [1:0]          ilas_lane_i,
   input  wire logic                lane_sync_done_i,
   output logic [15:0]              sample_word_o,
   output slcfg_pkg::slcfg_ilas_s   ilas_o,
   output logic                     scramble_on_o,
   output logic                     invert_o,
   output logic                     link_reset_o,
   output logic [1:0]               sync_opt_o,
   output logic [2:0]               ctrl_meaning_o,
   output logic [15:0]              lane_map_o,
   output logic [5:0]               frames_o
);
   import slcfg_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed
   {
      logic [7:0]  fmt;
      logic [7:0]  syncopt;
      logic [7:0]  quick;
      logic [7:0]  link;
      logic [7:0]  pol;
      logic [7:0]  device_identifier;
      logic [3:0]  bank_identifier;
      logic [4:0]  lid0;
      logic [4:0]  lid1;
      logic        scramble_lane_count;
      logic [4:0]  kf;
      logic [5:0]  frames;
      logic [7:0]  ctlb;
      logic [7:0]  remap_a;
      logic [7:0]  remap_b;
      logic [31:0] chk;
      logic [7:0]  rdata;
      logic [14:0] lfsr;
      logic [15:0] word;
      slcfg_ilas_s ilas;
      slcfg_ilas_e ost;
      logic [3:0]  idx;
      logic [1:0]  lane;
      logic        scr_on;
   } slcfg_st_s;

   slcfg_st_s st_reg;
   slcfg_st_s st_next;
   // ***************************************************
   // quick configuration decode
   // ***************************************************
   // maps a code to M, L, F; unknown codes flagged not ok
   function automatic slcfg_qc_s qc_decode(input logic [7:0] c);
      slcfg_qc_s q;
      q = '{ok: 1'b1, m: 8'h04, l: 5'h01, f: 8'h08};
      unique case (c)
         8'h41: q = '{ok: 1'b1, m: 8'h04, l: 5'h01, f: 8'h08};
         8'h42: q = '{ok: 1'b1, m: 8'h04, l: 5'h02, f: 8'h04};
         8'h44: q = '{ok: 1'b1, m: 8'h04, l: 5'h04, f: 8'h02};
         8'h22: q = '{ok: 1'b1, m: 8'h02, l: 5'h02, f: 8'h02};
         8'h21: q = '{ok: 1'b1, m: 8'h02, l: 5'h01, f: 8'h04};
         8'h11: q = '{ok: 1'b1, m: 8'h01, l: 5'h01, f: 8'h02};
         default: q.ok = 1'b0;
      endcase
      return q;
   endfunction
   slcfg_qc_s  qc;
   slcfg_qc_s  qc_wr;
   logic [7:0] base;
   logic [7:0] lid_l [4];
   logic [7:0] chk_l [4];
   logic [7:0] cfg_oct;
   logic [1:0] low2;
   logic [1:0] cs;
   logic       n14;
   logic       tail_rnd;
   logic       msb;
   logic       rst_link;
   logic [1:0] imode;

   assign qc       = qc_decode(st_reg.quick);
   assign qc_wr    = qc_decode(bus_i.wdata);
   assign cs       = st_reg.ctlb[7:6];
   assign n14      = (st_reg.ctlb[4:0] == `SLCFG_N14_M1);
   assign tail_rnd = st_reg.link[`SLCFG_B_TAILRND];
   assign rst_link = st_reg.link[`SLCFG_B_LINKRST];
   assign imode    = st_reg.link[3:2];
   // ***************************************************
   // checksum: field sum before packing
   // ***************************************************
   // lanes 2 and 3 take lane ids 0 and 1 plus two
   assign lid_l[0] = {3'h0, st_reg.lid0};
   assign lid_l[1] = {3'h0, st_reg.lid1};
   assign lid_l[2] = 8'({3'h0, st_reg.lid0} + 8'h02);
   assign lid_l[3] = 8'({3'h0, st_reg.lid1} + 8'h02);

   // modulo-256 sum of all non-lane fields
   assign base = 8'(st_reg.device_identifier + {4'h0, st_reg.bank_identifier}
      + {7'h0, st_reg.scramble_lane_count} + {3'h0, qc.l} - 8'h01
      + qc.f - 8'h01 + {3'h0, st_reg.kf} + qc.m - 8'h01
      + {6'h0, cs} + {3'h0, st_reg.ctlb[4:0]}
      + {5'h0, `SLCFG_SUBCLASS} + {3'h0, `SLCFG_NP_M1}
      + {5'h0, `SLCFG_JESDV});

   for (genvar g = 0; g < 4; g++)
   begin : g_chk
      assign chk_l[g] = 8'(base + lid_l[g]);
   end
   // ***************************************************
   // configuration octet for the current index
   // ***************************************************
   always_comb
   begin
      unique case (st_reg.idx)
         4'h0: cfg_oct = st_reg.device_identifier;
         4'h1: cfg_oct = {4'h0, st_reg.bank_identifier};
         4'h2: cfg_oct = lid_l[st_reg.lane];
         4'h3: cfg_oct = {st_reg.scramble_lane_count, 2'h0, 5'(qc.l - 5'h01)};
         4'h4: cfg_oct = 8'(qc.f - 8'h01);
         4'h5: cfg_oct = {3'h0, st_reg.kf};
         4'h6: cfg_oct = 8'(qc.m - 8'h01);
         4'h7: cfg_oct = {cs, 1'b0, st_reg.ctlb[4:0]};
         4'h8: cfg_oct = {`SLCFG_SUBCLASS, `SLCFG_NP_M1};
         4'h9: cfg_oct = {`SLCFG_JESDV, 5'h00};
         4'hD: cfg_oct = st_reg.chk[8*st_reg.lane +: 8];
         default: cfg_oct = 8'h00;
      endcase
   end

   // ***************************************************
   // sample formatting and tail / control bits
   // ***************************************************
   always_comb
   begin
      // two's complement flips the sign bit of offset binary
      msb = sample_i[15] ^ (st_reg.fmt[1:0] == 2'h1);
      unique case (cs)
         2'h0: low2 = tail_rnd ? st_reg.lfsr[1:0] : 2'h0;
         2'h1: low2 = {ctrl_flags_i[0], tail_rnd & st_reg.lfsr[0]};
         default: low2 = ctrl_flags_i;
      endcase
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb
   begin
      st_next = st_reg;
      st_next.lfsr = {st_reg.lfsr[13:0], st_reg.lfsr[14] ^ st_reg.lfsr[13]};
      for (int i = 0; i < 4; i++)
      begin
         st_next.chk[8*i +: 8] = chk_l[i];
      end
      // spare bits only exist at 14-bit resolution
      st_next.word = n14 ? {msb, sample_i[14:2], low2}
                         : {msb, sample_i[14:0]};
      // scrambler held off until lanes are synchronised
      st_next.scr_on = st_reg.scramble_lane_count & lane_sync_done_i & ~rst_link;

      // register writes
      if (bus_i.wr)
      begin
         unique case (bus_i.addr)
            `SLCFG_A_FMT:     st_next.fmt     = bus_i.wdata;
            `SLCFG_A_SYNCOPT: st_next.syncopt = bus_i.wdata;
            `SLCFG_A_QUICK:   st_next.quick   = qc_wr.ok ? bus_i.wdata
                                                : st_reg.quick;
            `SLCFG_A_LINK:    st_next.link    = bus_i.wdata;
            `SLCFG_A_POL:     st_next.pol     = bus_i.wdata;
            `SLCFG_A_DEVID:   st_next.device_identifier     = bus_i.wdata;
            `SLCFG_A_BANKID:  st_next.bank_identifier     = bus_i.wdata[3:0];
            `SLCFG_A_LANE0ID: st_next.lid0    = bus_i.wdata[4:0];
            `SLCFG_A_LANE1ID: st_next.lid1    = bus_i.wdata[4:0];
            `SLCFG_A_SCRL:    st_next.scramble_lane_count     = bus_i.wdata[7];
            `SLCFG_A_FRAMES:  st_next.kf      = bus_i.wdata[4:0];
            `SLCFG_A_CTLBITS: st_next.ctlb    = bus_i.wdata;
            `SLCFG_A_REMAPA:  st_next.remap_a = bus_i.wdata;
            `SLCFG_A_REMAPB:  st_next.remap_b = bus_i.wdata;
            default: ;
         endcase
      end

      st_next.frames = 6'({1'b0, st_next.kf} + 6'h01);

      // register reads, data stands one cycle later
      st_next.rdata = 8'h00;
      if (bus_i.rd)
      begin
         unique case (bus_i.addr)
            `SLCFG_A_FMT:     st_next.rdata = st_reg.fmt;
            `SLCFG_A_SYNCOPT: st_next.rdata = st_reg.syncopt;
            `SLCFG_A_QUICK:   st_next.rdata = st_reg.quick;
            `SLCFG_A_LINK:    st_next.rdata = st_reg.link;
            `SLCFG_A_POL:     st_next.rdata = st_reg.pol;
            `SLCFG_A_DEVID:   st_next.rdata = st_reg.device_identifier;
            `SLCFG_A_BANKID:  st_next.rdata = {4'h0, st_reg.bank_identifier};
            `SLCFG_A_LANE0ID: st_next.rdata = lid_l[0];
            `SLCFG_A_LANE1ID: st_next.rdata = lid_l[1];
            `SLCFG_A_SCRL:    st_next.rdata = {st_reg.scramble_lane_count, 2'h0,
                                               qc.l};
            `SLCFG_A_OCTF:    st_next.rdata = qc.f;
            `SLCFG_A_FRAMES:  st_next.rdata = {3'h0, st_reg.kf};
            `SLCFG_A_CONVS:   st_next.rdata = qc.m;
            `SLCFG_A_CTLBITS: st_next.rdata = st_reg.ctlb;
            `SLCFG_A_SWIDTH:  st_next.rdata = {3'h0,
                                 5'(`SLCFG_NP_M1 + 5'h01)};
            `SLCFG_A_SPF:     st_next.rdata = 8'h01;
            `SLCFG_A_DENSITY: st_next.rdata = 8'h00;
            `SLCFG_A_REMAPA:  st_next.rdata = st_reg.remap_a;
            `SLCFG_A_REMAPB:  st_next.rdata = st_reg.remap_b;
            default:
               if (bus_i.addr >= `SLCFG_A_CHK0 &&
                   bus_i.addr <= `SLCFG_A_CHK3)
                  st_next.rdata =
                     st_reg.chk[8*bus_i.addr[1:0] +: 8];
         endcase
      end

      // alignment configuration multiframe sequencer
      st_next.ilas = '{valid: 1'b0, k: 1'b0, octet: 8'h00};
      unique case (st_reg.ost)
         SLCFG_IDLE:
         begin
            // mode 01 disables, 10 repeats, others run once
            if (ilas_start_i && imode != 2'h1)
            begin
               st_next.ost  = SLCFG_QCH;
               st_next.lane = ilas_lane_i;
            end
         end
         SLCFG_QCH:
         begin
            st_next.ilas = '{valid: 1'b1, k: 1'b1,
                             octet: `SLCFG_K_START};
            st_next.ost  = SLCFG_CFG;
            st_next.idx  = 4'h0;
         end
         SLCFG_CFG:
         begin
            st_next.ilas = '{valid: 1'b1, k: 1'b0, octet: cfg_oct};
            st_next.idx  = 4'(st_reg.idx + 4'h1);
            if (st_reg.idx == `SLCFG_CFG_LAST)
            begin
               st_next.ost = (imode == 2'h2) ? SLCFG_QCH
                                             : SLCFG_IDLE;
            end
         end
      endcase
      // link held in reset: no sequence runs
      if (rst_link)
      begin
         st_next.ost  = SLCFG_IDLE;
         st_next.ilas = '{valid: 1'b0, k: 1'b0, octet: 8'h00};
      end
   end
   // ***************************************************
   // state register
   // ***************************************************
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_reg         <= '0;
         st_reg.quick   <= `SLCFG_R_QUICK;
         st_reg.scramble_lane_count     <= 1'b1;
         st_reg.kf      <= `SLCFG_R_FRAMES;
         st_reg.frames  <= 6'({1'b0, `SLCFG_R_FRAMES} + 6'h01);
         st_reg.ctlb    <= `SLCFG_R_CTLBITS;
         st_reg.remap_a <= `SLCFG_R_REMAPA;
         st_reg.remap_b <= `SLCFG_R_REMAPB;
         st_reg.lfsr    <= 15'h7FFF;
         st_reg.ost     <= SLCFG_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs, all straight from the state register
   assign rd_data_o      = st_reg.rdata;
   assign sample_word_o  = st_reg.word;
   assign ilas_o         = st_reg.ilas;
   assign scramble_on_o  = st_reg.scr_on;
   assign invert_o       = st_reg.pol[`SLCFG_B_INVERT];
   assign link_reset_o   = rst_link;
   assign sync_opt_o     = st_reg.syncopt[4:3];
   assign ctrl_meaning_o = st_reg.fmt[7:5];
   assign lane_map_o     = {st_reg.remap_b, st_reg.remap_a};
   assign frames_o       = st_reg.frames;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   tail_zero_a: assert property (n14 && cs == 2'h0 && !tail_rnd
      |=> sample_word_o[1:0] == 2'h0)
      else $error("tail bits not zero");
   tail_rand_a: assert property (n14 && cs == 2'h0 && tail_rnd
      |=> sample_word_o[1:0] == $past(st_reg.lfsr[1:0]))
      else $error("random tail bits wrong");
   ctrl_bits_a: assert property (n14 && cs == 2'h2
      |=> sample_word_o[1:0] == $past(ctrl_flags_i))
      else $error("control bits not inserted");
   frame_cnt_a: assert property (bus_i.wr &&
      bus_i.addr == `SLCFG_A_FRAMES
      |=> frames_o == 6'($past(bus_i.wdata[4:0])) + 6'h01)
      else $error("frame count not field plus one");
   scr_gate_a: assert property (scramble_on_o
      |-> $past(lane_sync_done_i))
      else $error("scrambling before lane sync");
   ilas_off_a: assert property (imode == 2'h1 &&
      st_reg.ost == SLCFG_IDLE |=> !ilas_o.valid)
      else $error("sequence ran while disabled");
   cfg_len_a: assert property (ilas_o.valid && ilas_o.k
      && !rst_link && $stable(st_reg.link)
      |=> (ilas_o.valid && !ilas_o.k) [*8])
      else $error("configuration octets broken");
   chk_read_a: assert property (bus_i.rd &&
      bus_i.addr == `SLCFG_A_CHK0
      |=> rd_data_o == $past(st_reg.chk[7:0]))
      else $error("lane 0 checksum read wrong");
   link_hold_a: assert property (link_reset_o
      |=> !ilas_o.valid)
      else $error("sequence during link reset");

   c_ilas_c:   cover property (ilas_o.valid && ilas_o.k);
   c_repeat_c: cover property (imode == 2'h2 && ilas_o.k
      && st_reg.idx == `SLCFG_CFG_LAST);
   c_ctrl_c:   cover property (n14 && cs == 2'h1);
endmodule

// [slcfg_rx_model.sv]
`timescale 1ns/1ps
`include "slcfg_consts.svh"
// ****************************************
// far-side receiver model
// ****************************************
module slcfg_rx_model
(
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   input  wire slcfg_pkg::slcfg_ilas_s ilas_i,
   input  wire logic                   sync_req_i,
   input  wire logic [3:0]             delay_i,
   output logic                        sync_done_o,
   output logic [13:0][7:0]            cfg_o,
   output int                          n_cfg_o,
   output int                          n_bad_o
);
   import slcfg_pkg::*;
   int idx;
   int cnt;
   // lane sync reported a chosen number of cycles after the request
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i || !sync_req_i)
      begin
         cnt <= 0;
         sync_done_o <= 1'b0;
      end
      else if (cnt < int'(delay_i))
         cnt <= cnt + 1;
      else
         sync_done_o <= 1'b1;
   end
   // start character opens a run, data octets fill it in order
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         idx <= 14;
         n_cfg_o <= 0;
         n_bad_o <= 0;
      end
      else if (ilas_i.valid && ilas_i.k)
      begin
         if (ilas_i.octet !== `SLCFG_K_START)
            n_bad_o <= n_bad_o + 1;
         idx <= 0;
      end
      else if (ilas_i.valid)
      begin
         if (idx < 14)
            cfg_o[idx] <= ilas_i.octet;
         else
            n_bad_o <= n_bad_o + 1;
         if (idx == 13)
            n_cfg_o <= n_cfg_o + 1;
         idx <= idx + 1;
      end
   end
endmodule

// [tb.sv]
`timescale 1ns/1ps
// ****************************************
// testbench for the link parameter block
// ****************************************
module tb;
   import slcfg_pkg::*;
   logic             clk;
   logic             resetn;
   slcfg_bus_s       bus;
   logic [7:0]       rd_data;
   logic [15:0]      sample;
   logic [1:0]       ctrl;
   logic             start;
   logic [1:0]       lane;
   logic             sync_done;
   logic             sync_req;
   logic [3:0]       dly;
   logic [15:0]      word;
   slcfg_ilas_s      ilas;
   logic             scr_on;
   logic             inv;
   logic             lrst;
   logic [1:0]       sopt;
   logic [2:0]       cmean;
   logic [15:0]      lmap;
   logic [5:0]       frames;
   logic [13:0][7:0] cfg;
   int               n_cfg;
   int               n_bad;
   int               errors;
   int               n_tests;
   int               seed = 32'hB040;
   int               nb;
   int               nz;
   logic             rd_q;
   logic [7:0]       exp_q[$];
   logic [15:0]      s;
   logic [15:0]      e;
   logic [15:0]      m;
   logic [1:0]       c;
   logic [7:0]       device_identifier = 8'h00;
   logic [7:0]       bank_identifier = 8'h00;
   logic [7:0]       lid0 = 8'h00;
   logic [7:0]       lid1 = 8'h00;
   logic [7:0]       scramble_lane_count = 8'h01;
   logic [7:0]       k = 8'h20;
   logic [7:0]       cs = 8'h00;
   logic [7:0]       n1 = 8'h0F;
   int               qi = 0;
   logic [7:0] q_t[6] = '{8'h41, 8'h42, 8'h44, 8'h22, 8'h21, 8'h11};
   logic [7:0] m_t[6] = '{8'h04, 8'h04, 8'h04, 8'h02, 8'h02, 8'h01};
   logic [7:0] l_t[6] = '{8'h01, 8'h02, 8'h04, 8'h02, 8'h01, 8'h01};
   logic [7:0] f_t[6] = '{8'h08, 8'h04, 8'h02, 8'h02, 8'h04, 8'h02};
   logic [7:0] ra[16] = '{8'h5E, 8'h6E, 8'h6F, 8'h70, 8'h71, 8'h72,
      8'h73, 8'h74, 8'h75, 8'h82, 8'h83, 8'h00, 8'h78, 8'h79, 8'h7A, 8'h7B};
   logic [7:0] re[16] = '{8'h41, 8'h81, 8'h08, 8'h1F, 8'h04, 8'h0F,
      8'h10, 8'h01, 8'h00, 8'h10, 8'h32, 8'h00, 8'h4A, 8'h4A, 8'h4C, 8'h4C};

   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   slcfg_top DUT
   (
      .sys_clk_i       (clk),
      .resetn_i        (resetn),
      .bus_i           (bus),
      .rd_data_o       (rd_data),
      .sample_i        (sample),
      .ctrl_flags_i    (ctrl),
      .ilas_start_i    (start),
      .ilas_lane_i     (lane),
      .lane_sync_done_i(sync_done),
      .sample_word_o   (word),
      .ilas_o          (ilas),
      .scramble_on_o   (scr_on),
      .invert_o        (inv),
      .link_reset_o    (lrst),
      .sync_opt_o      (sopt),
      .ctrl_meaning_o  (cmean),
      .lane_map_o      (lmap),
      .frames_o        (frames)
   );

   slcfg_rx_model rx
   (
      .clk_i      (clk),
      .resetn_i   (resetn),
      .ilas_i     (ilas),
      .sync_req_i (sync_req),
      .delay_i    (dly),
      .sync_done_o(sync_done),
      .cfg_o      (cfg),
      .n_cfg_o    (n_cfg),
      .n_bad_o    (n_bad)
   );

   task automatic check(input logic [15:0] got, exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // bus tasks: enter and leave just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      exp_q.push_back(x);
      @(posedge clk);
   endtask

   task automatic idle(input int n);
      bus <= '0;
      repeat (n) @(posedge clk);
      #1; // let registered outputs settle before they are compared
   endtask

   // expected checksum: field sum, fixed fields folded into one constant
   function automatic logic [7:0] lane0_checksum(input logic [7:0] lane0_identifier);
      return device_identifier + bank_identifier + lane0_identifier + scramble_lane_count + l_t[qi] + f_t[qi] + k + m_t[qi]
             + cs + n1 + 8'h0D;
   endfunction

   function automatic logic [7:0] lid_of(input int j);
      return (j[0] ? lid1 : lid0) + (j[1] ? 8'h02 : 8'h00);
   endfunction

   task automatic pulse(input logic [1:0] ln);
      nb = n_cfg;
      start <= 1'b1;
      lane <= ln;
      @(posedge clk);
      start <= 1'b0;
   endtask

   task automatic ilas_run(input int ln);
      logic [7:0] x[14];
      logic [7:0] lm;
      lm = l_t[qi] - 8'h01;
      x = '{device_identifier, bank_identifier, lid_of(ln), {scramble_lane_count[0], 2'b00, lm[4:0]}, f_t[qi] - 8'h01,
            k - 8'h01, m_t[qi] - 8'h01, {cs[1:0], 1'b0, n1[4:0]}, 8'h2F,
            8'h20, 8'h00, 8'h00, 8'h00, lane0_checksum(lid_of(ln))};
      pulse(2'(ln));
      for (int i = 0; i < 40 && n_cfg == nb; i++) @(posedge clk);
      check(16'(n_cfg - nb), 16'h0001, "cfg count");
      for (int i = 0; i < 14; i++)
         check(16'(cfg[i]), 16'(x[i]), "cfg octet");
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge clk) rd_q <= bus.rd;
   always @(negedge clk)
      if (rd_q)
         check(16'(rd_data), 16'(exp_q.pop_front()), "read");

   // watchdog
   initial
   begin
      #200000;
      errors++;
      summarize();
   end

   // main sequence
   initial
   begin
      resetn = 1'b0;
      bus = '0;
      sample = '0;
      ctrl = '0;
      start = 1'b0;
      lane = '0;
      sync_req = 1'b0;
      dly = 4'h0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 16; i++)
         rd(ra[i], re[i]);
      wr(8'h73, 8'hFF);
      wr(8'h6F, 8'h00);
      rd(8'h73, 8'h10);
      rd(8'h6F, 8'h08);
      idle(2);
      check(16'(frames), 16'h0020, "frames");
      check(lmap, 16'h3210, "lane map");
      $display("test reset values done");
      wr(8'h5F, 8'h01);
      for (int i = 0; i < 6; i++)
      begin
         qi = i;
         wr(8'h5E, q_t[i]);
         idle(2);
         rd(8'h71, m_t[i]);
         rd(8'h6E, {scramble_lane_count[0], 2'b00, l_t[i][4:0]});
         rd(8'h6F, f_t[i]);
         rd(8'h78, lane0_checksum(lid0));
      end
      wr(8'h5E, 8'h33);
      rd(8'h5E, q_t[5]);
      idle(2);
      $display("test quick codes done");
      for (int r = 0; r < 2; r++)
      begin
         device_identifier = 8'($random(seed));
         bank_identifier = 8'($random(seed)) & 8'h0F;
         lid0 = 8'($random(seed)) & 8'h0F;
         lid1 = 8'($random(seed)) & 8'h0F;
         scramble_lane_count = 8'($random(seed)) & 8'h01;
         cs = 8'($random(seed)) & 8'h03;
         n1 = r ? 8'h0D : 8'h0F;
         k = 8'h04 * (8'h01 + (8'($random(seed)) & 8'h07));
         while (k * f_t[qi] < 8'h11) k = k + 8'h04;
         wr(8'h5F, 8'h01);
         wr(8'h64, device_identifier);
         wr(8'h65, bank_identifier);
         wr(8'h66, lid0);
         wr(8'h67, lid1);
         wr(8'h6E, {scramble_lane_count[0], 7'h00});
         wr(8'h70, k - 8'h01);
         wr(8'h72, {cs[1:0], 1'b0, n1[4:0]});
         idle(2);
         rd(8'h64, device_identifier);
         rd(8'h65, bank_identifier);
         rd(8'h67, lid1);
         for (int j = 0; j < 4; j++)
            rd(8'h78 + 8'(j), lane0_checksum(lid_of(j)));
         wr(8'h5F, 8'h00);
         idle(2);
         check(16'(frames), 16'(k), "frames");
         for (int j = 0; j < 4; j++)
            ilas_run(j);
      end
      $display("test ilas content done");
      wr(8'h5F, 8'h04);
      idle(1);
      pulse(2'b00);
      idle(30);
      check(16'(n_cfg - nb), 16'h0000, "disabled");
      wr(8'h5F, 8'h08);
      idle(1);
      pulse(2'b01);
      idle(40);
      check(16'(n_cfg - nb > 1), 16'h0001, "repeat");
      wr(8'h5F, 8'h09);
      idle(2);
      check(16'(ilas.valid), 16'h0000, "abort");
      check(16'(n_bad), 16'h0000, "stream");
      $display("test ilas modes done");
      wr(8'h5F, 8'h01);
      nz = 0;
      for (int j = 0; j < 6; j++)
      begin
         wr(8'h72, j < 5 ? {2'(j), 1'b0, 5'h0D} : 8'h0F);
         wr(8'h14, {3'(j), 4'h0, j[1]});
         wr(8'h5F, {1'b0, j == 4, 6'h00});
         idle(2);
         check(16'(cmean), 16'(j), "meaning");
         m = (j == 4) ? 16'hFFFC : 16'hFFFF;
         for (int i = 0; i < 8; i++)
         begin
            s = 16'($random(seed));
            c = 2'($random(seed));
            sample <= s;
            ctrl <= c;
            e = s;
            e[15] = s[15] ^ j[1];
            if (j < 5)
               e[1:0] = (j % 4 == 0) ? 2'b00 : (j == 1) ? {c[0], 1'b0} : c;
            @(posedge clk);
            @(negedge clk);
            if (j == 4 && word[1:0] != 2'b00)
               nz++;
            check(word & m, e & m, "word");
            @(posedge clk);
         end
      end
      check(16'(nz > 0), 16'h0001, "random tail");
      $display("test sample path done");
      wr(8'h60, 8'h02);
      wr(8'h3A, 8'h18);
      wr(8'h82, 8'hAB);
      wr(8'h83, 8'hCD);
      wr(8'h6E, 8'h80);
      wr(8'h5F, 8'h01);
      idle(2);
      check(16'(inv), 16'h0001, "invert");
      check(16'(sopt), 16'h0003, "sync opt");
      check(lmap, 16'hCDAB, "lane map");
      check(16'(lrst), 16'h0001, "link reset");
      dly <= 4'h9;
      sync_req <= 1'b1;
      for (int i = 0; i < 20 && !sync_done; i++) @(posedge clk);
      idle(2);
      check(16'(sync_done), 16'h0001, "lane sync");
      check(16'(scr_on), 16'h0000, "scramble held");
      wr(8'h5F, 8'h00);
      idle(2);
      check(16'(scr_on), 16'h0001, "scramble on");
      wr(8'h6E, 8'h00);
      idle(2);
      check(16'(scr_on), 16'h0000, "scramble off");
      sync_req <= 1'b0;
      wr(8'h6E, 8'h80);
      idle(3);
      check(16'(scr_on), 16'h0000, "before sync");
      $display("test output controls done");
      summarize();
   end
endmodule
